// file: cco_counter_compare_output.sv
// Compare output, gate and interrupt logic for one counter channel
//
// Design decisions made here: the Wishbone interface to the registers and the address map.
`timescale 1ns/10ps

module cco_counter_compare_output #(
    parameter int STEP_CYCLES = cco_pkg::PULSE_STEP_CYCLES
) (
    input wire logic clk_i,                     // System clock, 10 MHz
    input wire logic rst_i,                     // Sync reset, active high
    input wire logic wb_cyc_i,                  // Wishbone cycle
    input wire logic wb_stb_i,                  // Wishbone strobe
    input wire logic wb_we_i,                   // Wishbone write enable
    input wire logic [cco_pkg::CCO_ADR_W-1:0] wb_adr_i, // Byte address
    input wire logic [3:0] wb_sel_i,            // Byte lane selects
    input wire logic [31:0] wb_dat_i,           // Write data
    output logic [31:0] wb_dat_o,               // Read data
    output logic wb_ack_o,                      // Acknowledge
    input wire logic [31:0] count_i,            // Count value, signed
    input wire logic count_up_i,                // 1 = counting up
    input wire logic hardware_gating_input_i,   // Gate pin, asynchronous
    output logic gate_open_o,                   // Counting enabled
    output logic digital_out_o,                 // Channel output
    output logic compare_status_flag_o,         // Comparator status
    output logic irq_gate_rise_o,               // Request pulse, gate 0-1
    output logic irq_gate_fall_o,               // Request pulse, gate 1-0
    output logic irq_cmp_o,                     // Request pulse, compare
    output logic irq_o                          // Level, unmasked pending
);
    import cco_pkg::*;

    typedef enum {PS_IDLE, PS_TIMED, PS_HOLD} cco_pulse_e;

    // ------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------
    logic [CTRL_W-1:0] ctrl_reg;
    logic [31:0] cmp_reg;
    logic [HYST_W-1:0] hyst_reg;
    logic [PULSE_W-1:0] pulse_reg;
    logic [IRQ_W-1:0] irq_stat_reg;
    logic [IRQ_W-1:0] irq_stat_next;
    logic [IRQ_W-1:0] irq_mask_reg;
    logic ack_reg;
    logic [31:0] rdat_reg;

    wire bus_req = wb_cyc_i & wb_stb_i;
    // Writes and read side effects land on the edge where ack is seen
    wire bus_done = bus_req & ack_reg;
    wire bus_wr = bus_done & wb_we_i;
    wire bus_rd = bus_done & ~wb_we_i;
    wire [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                         {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    wire sel_ctrl = (wb_adr_i == CCO_CTRL_OFS);
    wire sel_cmp = (wb_adr_i == CCO_CMP_OFS);
    wire sel_hyst = (wb_adr_i == CCO_HYST_OFS);
    wire sel_pulse = (wb_adr_i == CCO_PULSE_OFS);
    wire sel_status = (wb_adr_i == CCO_STATUS_OFS);
    wire sel_istat = (wb_adr_i == CCO_IRQ_STAT_OFS);
    wire sel_imask = (wb_adr_i == CCO_IRQ_MASK_OFS);

    wire [31:0] ctrl_w = ({21'h0, ctrl_reg} & ~wmask)
                       | (wb_dat_i & wmask);
    wire [31:0] cmp_w = (cmp_reg & ~wmask) | (wb_dat_i & wmask);
    wire [HYST_W-1:0] hyst_w = wb_sel_i[0] ? wb_dat_i[HYST_W-1:0]
                                           : hyst_reg;
    // 8-bit field in 2 ms steps covers exactly 0..510 ms
    wire [PULSE_W-1:0] pulse_w = wb_sel_i[0] ? wb_dat_i[PULSE_W-1:0]
                                             : pulse_reg;
    wire [IRQ_W-1:0] imask_w = wb_sel_i[0] ? wb_dat_i[IRQ_W-1:0]
                                           : irq_mask_reg;

    // ------------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------------
    wire cco_mode_e mode = cco_mode_e'(ctrl_reg[CTRL_MODE_LSB +: 2]);
    wire cco_dir_e main_dir = cco_dir_e'(ctrl_reg[CTRL_DIR_LSB +: 2]);
    wire hardware_gating_input_en = ctrl_reg[CTRL_HWG_BIT];
    wire software_gating_control = ctrl_reg[CTRL_SWG_BIT];
    wire manual_out = ctrl_reg[CTRL_MAN_BIT];
    wire ie_rise = ctrl_reg[CTRL_IE_RISE_BIT];
    wire ie_fall = ctrl_reg[CTRL_IE_FALL_BIT];
    wire ie_cmp = ctrl_reg[CTRL_IE_CMP_BIT];

    // ------------------------------------------------------------------
    // Hardware gate pin
    // ------------------------------------------------------------------
    logic gate_lvl;
    logic gate_rise;
    logic gate_fall;

    cco_sync u_gate_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(hardware_gating_input_i),
        .q_o(gate_lvl),
        .rise_o(gate_rise),
        .fall_o(gate_fall)
    );

    wire gate_open_next = software_gating_control
                        & (~hardware_gating_input_en | gate_lvl);

    // ------------------------------------------------------------------
    // Comparison arithmetic, 33-bit signed to avoid wrap at the limits
    // ------------------------------------------------------------------
    // Settings 0 and 1 both mean no band
    wire [HYST_W-1:0] hyst_eff = (hyst_reg > 8'h01) ? hyst_reg
                                                    : 8'h00;
    wire signed [32:0] cnt_x = {count_i[31], count_i};
    wire signed [32:0] cmp_x = {cmp_reg[31], cmp_reg};
    wire signed [32:0] hyst_x = {25'h0, hyst_eff};
    wire signed [32:0] band_lo = cmp_x - hyst_x;
    wire signed [32:0] band_hi = cmp_x + hyst_x;

    wire ge_set = (cnt_x >= cmp_x);
    wire ge_clr = (cnt_x < band_lo);
    wire le_set = (cnt_x <= cmp_x);
    wire le_clr = (cnt_x > band_hi);
    wire in_band = (cnt_x >= band_lo) && (cnt_x <= band_hi);

    logic [31:0] prev_cnt_reg;
    // Reaching means arriving at the value, not sitting on it
    wire arrive = (count_i == cmp_reg) && (prev_cnt_reg != count_i);
    wire dir_ok = (main_dir == DIR_UP) ? count_up_i :
                  (main_dir == DIR_DOWN) ? ~count_up_i :
                  1'b1;
    wire reach = arrive & dir_ok & (mode == MODE_PULSE);

    // ------------------------------------------------------------------
    // Level comparator with hysteresis
    // ------------------------------------------------------------------
    logic lvl_reg;
    logic lvl_next;

    always_comb begin
        lvl_next = 1'b0;
        case (mode)
            MODE_GE: begin
                if (ge_set) begin
                    lvl_next = 1'b1;
                end else if (ge_clr) begin
                    lvl_next = 1'b0;
                end else begin
                    lvl_next = lvl_reg;
                end
            end
            MODE_LE: begin
                if (le_set) begin
                    lvl_next = 1'b1;
                end else if (le_clr) begin
                    lvl_next = 1'b0;
                end else begin
                    lvl_next = lvl_reg;
                end
            end
            default: lvl_next = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // Pulse sequencer
    // ------------------------------------------------------------------
    cco_pulse_e ps_reg;
    cco_pulse_e ps_next;
    logic [PULSE_W-1:0] rem_reg;
    logic [PULSE_W-1:0] rem_next;

    cco_tick_if tick_if ();

    cco_timer #(
        .STEP_CYCLES(STEP_CYCLES)
    ) u_step_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tif(tick_if)
    );

    always_comb begin
        ps_next = ps_reg;
        rem_next = rem_reg;
        tick_if.restart = 1'b0;
        case (ps_reg)
            PS_IDLE: begin
                if (reach && (pulse_reg == '0)) begin
                    ps_next = PS_HOLD;
                end else if (reach) begin
                    // Length is captured here; later writes wait
                    ps_next = PS_TIMED;
                    rem_next = pulse_reg;
                    tick_if.restart = 1'b1;
                end
            end
            PS_TIMED: begin
                // Further arrivals are ignored until the pulse ends
                if (mode != MODE_PULSE) begin
                    ps_next = PS_IDLE;
                end else if (tick_if.tick) begin
                    rem_next = rem_reg - 1'b1;
                    if (rem_reg == 8'h01) begin
                        ps_next = PS_IDLE;
                    end
                end
            end
            PS_HOLD: begin
                if ((mode != MODE_PULSE) || !in_band) begin
                    ps_next = PS_IDLE;
                end
            end
            default: ps_next = PS_IDLE;
        endcase
    end

    // ------------------------------------------------------------------
    // Output selection
    // ------------------------------------------------------------------
    logic out_reg;
    logic flag_reg;
    wire pulse_on = (ps_next != PS_IDLE);
    wire out_next = (mode == MODE_NONE) ? manual_out :
                    (mode == MODE_PULSE) ? pulse_on :
                    lvl_next;
    wire flag_next = (mode == MODE_NONE) ? 1'b0 :
                     (mode == MODE_PULSE) ? pulse_on :
                     lvl_next;

    // ------------------------------------------------------------------
    // Interrupt events
    // ------------------------------------------------------------------
    logic ev_rise_reg;
    logic ev_fall_reg;
    logic ev_cmp_reg;
    wire ev_rise = gate_rise & software_gating_control & ie_rise;
    wire ev_fall = gate_fall & software_gating_control & ie_fall;
    wire ev_cmp = flag_next & ~flag_reg & ie_cmp;
    wire [IRQ_W-1:0] ev_vec = {ev_cmp_reg, ev_fall_reg, ev_rise_reg};

    // A read clears the sticky bits, but a new event in that cycle wins
    always_comb begin
        irq_stat_next = irq_stat_reg;
        if (bus_rd && sel_istat) begin
            irq_stat_next = '0;
        end
        irq_stat_next = irq_stat_next | ev_vec;
    end

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    wire [31:0] status_word = {28'h0000000, (ps_reg != PS_IDLE),
                               gate_open_o, out_reg, flag_reg};
    wire [31:0] rdat_mux =
        sel_ctrl ? {21'h0, ctrl_reg} :
        sel_cmp ? cmp_reg :
        sel_hyst ? {24'h000000, hyst_reg} :
        sel_pulse ? {24'h000000, pulse_reg} :
        sel_status ? status_word :
        sel_istat ? {29'h0, irq_stat_reg} :
        sel_imask ? {29'h0, irq_mask_reg} :
        32'h0000_0000;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            rdat_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= bus_req & ~ack_reg;
            if (bus_req && !ack_reg) begin
                rdat_reg <= rdat_mux;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= CTRL_RST;
            cmp_reg <= CMP_RST;
            hyst_reg <= HYST_RST;
            pulse_reg <= PULSE_RST;
            irq_mask_reg <= IRQ_RST;
        end else if (bus_wr) begin
            if (sel_ctrl) begin
                ctrl_reg <= ctrl_w[CTRL_W-1:0];
            end else if (sel_cmp) begin
                cmp_reg <= cmp_w;
            end else if (sel_hyst) begin
                hyst_reg <= hyst_w;
            end else if (sel_pulse) begin
                pulse_reg <= pulse_w;
            end else if (sel_imask) begin
                irq_mask_reg <= imask_w;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ps_reg <= PS_IDLE;
            rem_reg <= '0;
            lvl_reg <= 1'b0;
            prev_cnt_reg <= 32'h0000_0000;
            out_reg <= 1'b0;
            flag_reg <= 1'b0;
            gate_open_o <= 1'b0;
        end else begin
            ps_reg <= ps_next;
            rem_reg <= rem_next;
            lvl_reg <= lvl_next;
            prev_cnt_reg <= count_i;
            out_reg <= out_next;
            flag_reg <= flag_next;
            gate_open_o <= gate_open_next;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ev_rise_reg <= 1'b0;
            ev_fall_reg <= 1'b0;
            ev_cmp_reg <= 1'b0;
            irq_stat_reg <= IRQ_RST;
        end else begin
            ev_rise_reg <= ev_rise;
            ev_fall_reg <= ev_fall;
            ev_cmp_reg <= ev_cmp;
            irq_stat_reg <= irq_stat_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdat_reg;
    assign digital_out_o = out_reg;
    assign compare_status_flag_o = flag_reg;
    assign irq_gate_rise_o = ev_rise_reg;
    assign irq_gate_fall_o = ev_fall_reg;
    assign irq_cmp_o = ev_cmp_reg;
    assign irq_o = |(irq_stat_reg & irq_mask_reg);

endmodule : cco_counter_compare_output

// file: cco_pkg.sv
// Package: register map, field layout, reset values and timing constants
package cco_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses, one 32-bit word each)
    // ------------------------------------------------------------------
    localparam int CCO_ADR_W = 8;
    localparam logic [7:0] CCO_CTRL_OFS = 8'h00;
    localparam logic [7:0] CCO_CMP_OFS = 8'h04;
    localparam logic [7:0] CCO_HYST_OFS = 8'h08;
    localparam logic [7:0] CCO_PULSE_OFS = 8'h0c;
    localparam logic [7:0] CCO_STATUS_OFS = 8'h10;
    localparam logic [7:0] CCO_IRQ_STAT_OFS = 8'h14;
    localparam logic [7:0] CCO_IRQ_MASK_OFS = 8'h18;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_DIR_LSB = 2;
    localparam int CTRL_HWG_BIT = 4;
    localparam int CTRL_SWG_BIT = 5;
    localparam int CTRL_MAN_BIT = 6;
    localparam int CTRL_IE_RISE_BIT = 8;
    localparam int CTRL_IE_FALL_BIT = 9;
    localparam int CTRL_IE_CMP_BIT = 10;
    localparam int CTRL_W = 11;
    localparam int ST_FLAG_BIT = 0;
    localparam int ST_OUT_BIT = 1;
    localparam int ST_GATE_BIT = 2;
    localparam int ST_PULSE_BIT = 3;
    localparam int IRQ_RISE_BIT = 0;
    localparam int IRQ_FALL_BIT = 1;
    localparam int IRQ_CMP_BIT = 2;
    localparam int IRQ_W = 3;
    localparam int HYST_W = 8;
    localparam int PULSE_W = 8;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [CTRL_W-1:0] CTRL_RST = 11'h0;
    localparam logic [31:0] CMP_RST = 32'h0000_0000;
    localparam logic [HYST_W-1:0] HYST_RST = 8'h00;
    localparam logic [PULSE_W-1:0] PULSE_RST = 8'h00;
    localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

    // ------------------------------------------------------------------
    // Timing: pulse length is set in steps of 2 ms, 0 to 510 ms
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 10_000_000;
    localparam int PULSE_STEP_MS = 2;
    localparam int PULSE_MAX_MS = 510;
    localparam int PULSE_STEP_CYCLES = PULSE_STEP_MS * (CLK_HZ / 1000);

    // ------------------------------------------------------------------
    // Modes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_NONE, MODE_GE, MODE_LE, MODE_PULSE
    } cco_mode_e;
    typedef enum logic [1:0] {
        DIR_NONE, DIR_UP, DIR_DOWN, DIR_RSVD
    } cco_dir_e;

endpackage : cco_pkg

// file: cco_tick_if.sv
// Interface: restart and tick between the compare logic and the step timer
`timescale 1ns/10ps
interface cco_tick_if;
    logic restart;
    logic tick;
    modport ctrl (output restart, input tick);
    modport timer (input restart, output tick);
endinterface : cco_tick_if

// file: cco_sync.sv
// Two-stage synchroniser with edge pulses for an asynchronous pin
`timescale 1ns/10ps
module cco_sync (
    input wire logic clk_i,  // System clock
    input wire logic rst_i,  // Synchronous reset, active high
    input wire logic d_i,    // Asynchronous pin level
    output logic q_o,        // Synchronised level
    output logic rise_o,     // One-cycle pulse on 0-1 edge
    output logic fall_o      // One-cycle pulse on 1-0 edge
);
    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    // Only sync_reg reads meta_reg; edges compare the two later stages
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end else begin
            meta_reg <= d_i;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    assign q_o = sync_reg;
    assign rise_o = sync_reg & ~last_reg;
    assign fall_o = ~sync_reg & last_reg;
endmodule : cco_sync

// file: cco_timer.sv
// Step timer: one tick every STEP_CYCLES, restartable
`timescale 1ns/10ps
module cco_timer #(
    parameter int STEP_CYCLES = cco_pkg::PULSE_STEP_CYCLES
) (
    input wire logic clk_i,  // System clock
    input wire logic rst_i,  // Synchronous reset, active high
    cco_tick_if.timer tif    // Restart in, tick out
);
    localparam int CW = $clog2(STEP_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(STEP_CYCLES - 1);

    logic [CW-1:0] cnt_reg;
    wire at_end = (cnt_reg == LAST);

    // Restart re-phases the step so a pulse is timed from its start
    always_ff @(posedge clk_i) begin
        if (rst_i || tif.restart || at_end) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    assign tif.tick = at_end & ~tif.restart;
endmodule : cco_timer

// file: cco_actuator_model.sv
// Actuator model: measures how long the channel output stays asserted
`timescale 1ns/10ps
module cco_actuator_model (
    input wire logic clk_i,         // System clock
    input wire logic rst_i,         // Sync reset, active high
    input wire logic drive_i,       // Channel output level
    output logic [15:0] width_o     // Cycles of the last high period
);
    logic [15:0] run_reg;
    // A load only sees a finished pulse, so width updates on the fall
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_reg <= 16'h0;
            width_o <= 16'h0;
        end else if (drive_i) begin
            run_reg <= run_reg + 16'h1;
        end else begin
            if (run_reg != 16'h0) width_o <= run_reg;
            run_reg <= 16'h0;
        end
    end
endmodule : cco_actuator_model

// file: cco_counter_compare_output_properties.sv
// Checker: request pulses, gate edges and reset state at the ports
`timescale 1ns/10ps
module cco_counter_compare_output_properties (
    input wire logic clk_i,                    // System clock
    input wire logic rst_i,                    // Sync reset
    input wire logic wb_ack_o,                 // Bus acknowledge
    input wire logic hardware_gating_input_i,  // Gate pin
    input wire logic digital_out_o,            // Channel output
    input wire logic compare_status_flag_o,    // Compare flag
    input wire logic irq_gate_rise_o,          // Gate 0-1 request
    input wire logic irq_gate_fall_o,          // Gate 1-0 request
    input wire logic irq_cmp_o,                // Compare request
    input wire logic irq_o                     // Level interrupt
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    reset_state_a: assert property (disable iff (1'b0)
        rst_i |=> !digital_out_o && !compare_status_flag_o && !irq_o)
        else $error("outputs not cleared by reset");
    cmp_pulse_a: assert property (irq_cmp_o |=> !irq_cmp_o)
        else $error("compare request longer than one cycle");
    rise_pulse_a: assert property (
        irq_gate_rise_o |=> !irq_gate_rise_o)
        else $error("gate rise request longer than one cycle");
    fall_pulse_a: assert property (
        irq_gate_fall_o |=> !irq_gate_fall_o)
        else $error("gate fall request longer than one cycle");
    cmp_cause_a: assert property (irq_cmp_o |->
        compare_status_flag_o && !$past(compare_status_flag_o))
        else $error("compare request without flag rise");
    rise_cause_a: assert property (
        irq_gate_rise_o |-> $past(hardware_gating_input_i, 2))
        else $error("gate rise request while pin low");
    fall_cause_a: assert property (
        irq_gate_fall_o |-> !$past(hardware_gating_input_i, 2))
        else $error("gate fall request while pin high");
    single_ack_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge longer than one cycle");
endmodule : cco_counter_compare_output_properties

bind cco_counter_compare_output cco_counter_compare_output_properties u_props (
    .clk_i(clk_i), .rst_i(rst_i), .wb_ack_o(wb_ack_o),
    .hardware_gating_input_i(hardware_gating_input_i),
    .digital_out_o(digital_out_o), .irq_o(irq_o),
    .compare_status_flag_o(compare_status_flag_o), .irq_cmp_o(irq_cmp_o),
    .irq_gate_rise_o(irq_gate_rise_o), .irq_gate_fall_o(irq_gate_fall_o));

// file: tb_top.sv
// Testbench: register access, compare modes, pulses and interrupts
`timescale 1ns/10ps
module tb_top;
    import cco_pkg::*;
    localparam int STEP = 10;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h0;
    logic [31:0] wdat = 32'h0, rdat, cnt = 32'h0, q;
    logic up = 1'b1, pin = 1'b0, ack, gate, dout, flag, i_r, i_f, i_c, irq;
    logic [15:0] width;
    int fail_count = 0, checks_done = 0;
    always #50 clk_i = ~clk_i;
    cco_counter_compare_output #(.STEP_CYCLES(STEP)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .count_i(cnt), .count_up_i(up),
        .hardware_gating_input_i(pin), .gate_open_o(gate),
        .digital_out_o(dout), .compare_status_flag_o(flag),
        .irq_gate_rise_o(i_r), .irq_gate_fall_o(i_f), .irq_cmp_o(i_c),
        .irq_o(irq));
    cco_actuator_model act (.clk_i(clk_i), .rst_i(rst_i), .drive_i(dout),
        .width_o(width));
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task test_done;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : test_done
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1) begin
            fail_count++;
            test_done;
        end
    endtask : bus
    task rchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(q, exp);
    endtask : rchk
    task cy(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : cy
    task cn(input logic [31:0] c, input logic u);
        @(posedge clk_i);
        cnt <= c;
        up <= u;
        cy(2);
    endtask : cn
    task pn(input logic v);
        @(posedge clk_i);
        pin <= v;
        cy(8);
    endtask : pn
    task wid(input int e);
        cy(30);
        chk(32'((width >= e - 1) && (width <= e + 1)), 32'h1);
    endtask : wid
    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        rchk(CCO_CTRL_OFS, 32'h0);
        rchk(CCO_PULSE_OFS, 32'h0);
        rchk(8'h1c, 32'h0);
        bus(1'b1, CCO_CMP_OFS, 32'h64);
        bus(1'b1, CCO_CTRL_OFS, 32'h40);
        cn(32'h64, 1'b1);
        chk(32'({dout, flag}), 32'h2);
        bus(1'b1, CCO_CTRL_OFS, 32'h1);
        cn(32'h63, 1'b1);
        chk(32'({dout, flag}), 32'h0);
        cn(32'h64, 1'b1);
        chk(32'({dout, flag}), 32'h3);
        rchk(CCO_IRQ_STAT_OFS, 32'h0);
        bus(1'b1, CCO_IRQ_MASK_OFS, 32'h4);
        bus(1'b1, CCO_CTRL_OFS, 32'h401);
        cn(32'h63, 1'b1);
        cn(32'h64, 1'b1);
        chk(32'(irq), 32'h1);
        rchk(CCO_IRQ_STAT_OFS, 32'h4);
        rchk(CCO_IRQ_STAT_OFS, 32'h0);
        chk(32'(irq), 32'h0);
        bus(1'b1, CCO_HYST_OFS, 32'h5);
        cn(32'h61, 1'b0);
        chk(32'(flag), 32'h1);
        cn(32'h5e, 1'b0);
        chk(32'(flag), 32'h0);
        bus(1'b1, CCO_HYST_OFS, 32'h0);
        bus(1'b1, CCO_CTRL_OFS, 32'h2);
        cn(32'h65, 1'b1);
        chk(32'({dout, flag}), 32'h0);
        cn(32'h64, 1'b1);
        chk(32'({dout, flag}), 32'h3);
        bus(1'b1, CCO_PULSE_OFS, 32'h1);
        bus(1'b1, CCO_CTRL_OFS, 32'h7);
        cn(32'h65, 1'b0);
        cn(32'h64, 1'b0);
        chk(32'(dout), 32'h0);
        cn(32'h63, 1'b1);
        cn(32'h64, 1'b1);
        chk(32'(dout), 32'h1);
        // Length change and re-reach both land inside the running pulse
        bus(1'b1, CCO_PULSE_OFS, 32'h2);
        cn(32'h63, 1'b1);
        cn(32'h64, 1'b1);
        wid(STEP);
        cn(32'h63, 1'b1);
        cn(32'h64, 1'b1);
        wid(2 * STEP);
        bus(1'b1, CCO_PULSE_OFS, 32'h0);
        bus(1'b1, CCO_CTRL_OFS, 32'hb);
        cn(32'h65, 1'b0);
        cn(32'h64, 1'b0);
        cy(STEP * 3);
        chk(32'(dout), 32'h1);
        rchk(CCO_STATUS_OFS, 32'hb);
        cn(32'h65, 1'b1);
        chk(32'(dout), 32'h0);
        bus(1'b1, CCO_CTRL_OFS, 32'h310);
        pn(1'b1);
        pn(1'b0);
        rchk(CCO_IRQ_STAT_OFS, 32'h0);
        chk(32'(gate), 32'h0);
        bus(1'b1, CCO_CTRL_OFS, 32'h330);
        cy(2);
        chk(32'(gate), 32'h0);
        pn(1'b1);
        chk(32'(gate), 32'h1);
        pn(1'b0);
        rchk(CCO_IRQ_STAT_OFS, 32'h3);
        bus(1'b1, CCO_CTRL_OFS, 32'h20);
        cy(2);
        chk(32'(gate), 32'h1);
        test_done;
    end
endmodule : tb_top
